// [hw/data_fifo.sv]
// Synchronous FIFO with valid and ready on both sides.
module data_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Room for one more word.
  output logic [WIDTH-1:0] out_data, // Head word, read from memory at the read pointer.
  output logic out_valid, // Head word is valid.
  input wire logic out_ready // Consumer takes the head word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // There is no output register; out_data follows rd_ptr, so a pop shows the next word right after the edge.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != '0);

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head word is read from memory at the current read pointer.
  assign out_data = mem[rd_ptr];
endmodule

// [hw/sysbus_data_phase.sv]
// Data-phase engine of one agent on a shared multi-agent system bus.
// Functional notes
// [R1] Data path is 64 bits, all lines.
// [R2] Driver asserts data-valid on every transfer.
// [R3] Strobe may pause; capture only when asserted.
// [R4] Driver asserts bus-busy while using data bus.
// [R5] Take bus only after owner drops busy.
// [R6] Completion_postpone_n input marks out-of-order completion possible.
// [R7] Addressed memory or I/O agent normally defers.
// [R8] Check lines driven by the data driver.
// [R9] ECC enable captured at configuration, held.
// [R10] All signals active low, sampled on clock.
module sysbus_data_phase
  import sysbus_data_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic CLOCK, // Bus clock.
  input wire logic RST_B, // Asynchronous reset, active low.
  input wire logic ECC_STRAP_N, // Power-on ECC choice, low enables.
  input wire logic [WIDTH-1:0] TX_DATA, // Outbound word.
  input wire logic TX_VALID, // Outbound word offered.
  output logic TX_READY, // Outbound FIFO has room.
  input wire logic TX_LAST, // Last word of this data phase.
  input wire logic TX_PAUSE, // Request an idle clock.
  input wire logic [WIDTH-1:0] DATA_N_IN, // Data lines as seen on the bus.
  output logic [WIDTH-1:0] DATA_N_OUT, // Data lines driven value.
  output logic DATA_N_OE, // Data line drive enable.
  input wire logic [CHECK_W-1:0] DATA_CHECK_BITS_N_IN, // Check lines as seen.
  output logic [CHECK_W-1:0] DATA_CHECK_BITS_N_OUT, // Check lines driven value.
  output logic DATA_CHECK_BITS_N_OE, // Check line drive enable.
  input wire logic DATA_VALID_STROBE_N_IN, // Strobe as seen.
  output logic DATA_VALID_STROBE_N_OUT, // Strobe driven value.
  output logic DATA_VALID_STROBE_N_OE, // Strobe drive enable.
  input wire logic DATA_BUS_IN_USE_N_IN, // Busy as seen.
  output logic DATA_BUS_IN_USE_N_OUT, // Busy driven value.
  output logic DATA_BUS_IN_USE_N_OE, // Busy drive enable.
  input wire logic COMPLETION_POSTPONE_N, // Completion_postpone_n input from addressed agent.
  output logic [WIDTH-1:0] RX_DATA, // Captured inbound word.
  output logic RX_VALID, // One-cycle pulse per captured word.
  output logic RX_CHECK_ERROR, // Pulse on check mismatch with ECC on.
  output logic DEFERRED, // Synchronised completion_postpone_n, inverted: high while the pin is low.
  output logic ECC_ON, // Held ECC enable.
  output logic BUS_OWNED // This agent holds the data bus.
);
  drive_state_t state;
  logic [1:0] busy_sync;
  logic [1:0] strobe_sync;
  logic [1:0] completion_postpone_n_sync;
  logic [1:0] strap_sync;
  logic [WIDTH-1:0] data_s1;
  logic [WIDTH-1:0] data_s2;
  logic [CHECK_W-1:0] check_s1;
  logic [CHECK_W-1:0] check_s2;
  logic [WIDTH-1:0] head_data;
  logic head_valid;
  logic head_take;
  logic [WIDTH:0] fifo_word;
  logic [WIDTH:0] head_word;
  logic last_seen;
  logic cfg_done;
  logic [1:0] cfg_wait;
  logic oe_s1;
  logic oe_s2;
  logic strobe_seen;

  assign fifo_word = {TX_LAST, TX_DATA};
  assign head_data = head_word[WIDTH-1:0];

  // Outbound words wait here so a stalled bus pushes back on the source.
  data_fifo #(
    .WIDTH(WIDTH + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst_b(RST_B),
    .in_data(fifo_word),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .out_data(head_word),
    .out_valid(head_valid),
    .out_ready(head_take)
  );

  // Bus pins come from other agents; two flops before any logic looks.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      busy_sync <= SYNC_RESET;
      strobe_sync <= SYNC_RESET;
      completion_postpone_n_sync <= SYNC_RESET;
      strap_sync <= SYNC_RESET;
      data_s1 <= '0;
      data_s2 <= '0;
      check_s1 <= '0;
      check_s2 <= '0;
      oe_s1 <= 1'h0;
      oe_s2 <= 1'h0;
    end else begin
      // Our own strobe enable, delayed to line up with the synchronised strobe pin.
      oe_s1 <= DATA_VALID_STROBE_N_OE;
      oe_s2 <= oe_s1;
      busy_sync <= {busy_sync[0], DATA_BUS_IN_USE_N_IN}; // [R10]
      strobe_sync <= {strobe_sync[0], DATA_VALID_STROBE_N_IN}; // [R10]
      completion_postpone_n_sync <= {completion_postpone_n_sync[0], COMPLETION_POSTPONE_N}; // [R10]
      strap_sync <= {strap_sync[0], ECC_STRAP_N};
      data_s1 <= DATA_N_IN; // [R1]
      data_s2 <= data_s1;
      check_s1 <= DATA_CHECK_BITS_N_IN;
      check_s2 <= check_s1;
    end
  end

  // The ECC choice is latched once and held until the next reset.
  // Two clocks pass first, so the strap flops hold the pin and not their reset value.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_wait <= 2'h0;
      cfg_done <= 1'h0;
      ECC_ON <= ECC_ENABLE_RESET;
    end else begin
      cfg_wait <= {cfg_wait[0], 1'h1};
      if (cfg_wait[1] && !cfg_done) begin
        cfg_done <= 1'h1;
        ECC_ON <= !strap_sync[1]; // [R9]
      end
    end
  end

  // Completion_postpone_n is only reported; ordering decisions belong to the transaction layer.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      DEFERRED <= 1'h0;
    end else begin
      DEFERRED <= !completion_postpone_n_sync[1]; // [R6] [R7]
    end
  end

  // Pop the head each cycle the strobe goes out; pause inserts an idle clock.
  assign head_take = (state == DRIVE) && head_valid && !TX_PAUSE && !last_seen;

  // Ownership: start only once the bus reads idle, give it up after the last word.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= IDLE;
      last_seen <= 1'h0;
    end else begin
      unique case (state)
        IDLE: begin
          last_seen <= 1'h0;
          if (head_valid && busy_sync[1] && cfg_done) begin
            state <= DRIVE; // [R5]
          end
        end
        DRIVE: begin
          if (head_take && head_word[WIDTH]) begin
            last_seen <= 1'h1;
          end
          if (last_seen) begin
            state <= RELEASE;
          end
        end
        RELEASE: begin
          // One cycle with busy dropped before we may claim again.
          state <= IDLE;
        end
      endcase
    end
  end

  // Driven pins; busy covers the whole data phase, strobe marks each word.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      DATA_N_OUT <= '1;
      DATA_N_OE <= 1'h0;
      DATA_CHECK_BITS_N_OUT <= '1;
      DATA_CHECK_BITS_N_OE <= 1'h0;
      DATA_VALID_STROBE_N_OUT <= 1'h1;
      DATA_VALID_STROBE_N_OE <= 1'h0;
      DATA_BUS_IN_USE_N_OUT <= 1'h1;
      DATA_BUS_IN_USE_N_OE <= 1'h0;
      BUS_OWNED <= 1'h0;
    end else begin
      BUS_OWNED <= (state == DRIVE) && !last_seen;
      DATA_BUS_IN_USE_N_OE <= (state == DRIVE) && !last_seen;
      DATA_BUS_IN_USE_N_OUT <= !((state == DRIVE) && !last_seen); // [R4]
      DATA_VALID_STROBE_N_OE <= (state == DRIVE) && !last_seen;
      DATA_VALID_STROBE_N_OUT <= !head_take; // [R2] [R3]
      DATA_N_OE <= (state == DRIVE) && !last_seen; // [R1]
      DATA_CHECK_BITS_N_OE <= (state == DRIVE) && !last_seen && ECC_ON; // [R8]
      if (head_take) begin
        DATA_N_OUT <= ~head_data;
        DATA_CHECK_BITS_N_OUT <= ~check_code(head_data); // [R8]
      end
    end
  end

  // Inbound capture: only on strobe cycles and only when another agent drives.
  // The enable is compared at the same pipeline depth as the pin, so our own words never echo back.
  assign strobe_seen = !strobe_sync[1] && !oe_s2; // [R3]
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RX_DATA <= '0;
      RX_VALID <= 1'h0;
      RX_CHECK_ERROR <= 1'h0;
    end else begin
      RX_VALID <= strobe_seen; // [R3]
      RX_CHECK_ERROR <= strobe_seen && ECC_ON && (~check_s2 != check_code(~data_s2)); // [R9]
      if (strobe_seen) begin
        RX_DATA <= ~data_s2;
      end
    end
  end
endmodule

// [hw/sysbus_data_pkg.sv]
// Shared constants and types for the system bus data-phase block.
package sysbus_data_pkg;
  localparam int DATA_W = 64;
  localparam int CHECK_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic ECC_ENABLE_RESET = 1'h0;
  localparam logic [7:0] GAP_COUNT_RESET = 8'h00;

  typedef enum logic [2:0] {
    IDLE = 3'h1,
    DRIVE = 3'h2,
    RELEASE = 3'h4
  } drive_state_t;

  // Check code over one data word: each check bit is the parity of one byte lane.
  function automatic logic [CHECK_W-1:0] check_code(input logic [DATA_W-1:0] d);
    logic [CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < CHECK_W; i++) begin
      c[i] = ^d[i*8 +: 8];
    end
    return c;
  endfunction
endpackage

// [verification/bus_peer_model.sv]
// Far-side bus agent that drives data phases onto the shared lines.
module bus_peer_model (
  input wire logic clk, // Clock.
  input wire logic busy_n, // Busy line.
  output logic [63:0] d, // Data.
  output logic [7:0] c, // Check bits.
  output logic s, // Strobe.
  output logic b, // Busy.
  output logic oe // Driving.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released at rest, so the pull-ups show ones.
  initial begin
    {s, b, d, c} = '1;
    oe = 1'h0;
  end
  // Sends n words; an idle clock with garbage data may follow the first.
  task automatic send(input logic [63:0] base, input int n, input bit pause, input bit bad);
    logic [63:0] w;
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      #1;
      if (busy_n) break;
    end
    oe = 1'h1;
    b = 1'h0;
    for (int i = 0; i < n; i++) begin
      w = base + i;
      d = ~w;
      for (int j = 0; j < 8; j++) c[j] = ~^w[j*8 +: 8] ^ bad;
      s = 1'h0;
      @(posedge clk);
      #1;
      if (pause && i == 0) begin
        s = 1'h1;
        d = ~d;
        @(posedge clk);
        #1;
      end
    end
    {oe, s, b} = 3'h3;
  endtask
endmodule

// [verification/sysbus_data_phase_checker.sv]
// Port-level checks on the data-phase block.
module sysbus_data_phase_checker #(parameter int WIDTH = 64) (
  input wire logic CLOCK, // Clock.
  input wire logic RST_B, // Reset.
  input wire logic [WIDTH-1:0] DATA_N_IN, // Pins.
  input wire logic [WIDTH-1:0] RX_DATA, // Word.
  input wire logic DATA_N_OE, // Drive.
  input wire logic DATA_CHECK_BITS_N_OE, // Drive.
  input wire logic DATA_VALID_STROBE_N_IN, // Pin.
  input wire logic DATA_VALID_STROBE_N_OUT, // Out.
  input wire logic DATA_BUS_IN_USE_N_IN, // Pin.
  input wire logic DATA_BUS_IN_USE_N_OUT, // Out.
  input wire logic COMPLETION_POSTPONE_N, // Pin.
  input wire logic RX_VALID, // Pulse.
  input wire logic DEFERRED, // Level.
  input wire logic ECC_ON // Level.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // A peer word on the pins while this agent stays off the data lines.
  sequence s_in;
    !DATA_VALID_STROBE_N_IN && !DATA_N_OE ##1 !DATA_N_OE [*2];
  endsequence
  AST_STB: assert property (!DATA_VALID_STROBE_N_OUT |-> DATA_N_OE) else $error("bare strobe");
  AST_BSY: assert property (DATA_N_OE |-> !DATA_BUS_IN_USE_N_OUT) else $error("no busy");
  AST_CHK: assert property (DATA_CHECK_BITS_N_OE |-> DATA_N_OE && ECC_ON) else $error("check drive");
  AST_ECC: assert property ($past(RST_B, 4) |-> $stable(ECC_ON)) else $error("ecc moved");
  AST_RX: assert property (s_in |-> ##1 RX_VALID && RX_DATA == ~$past(DATA_N_IN, 3)) else $error("rx lost");
  AST_RXC: assert property (RX_VALID |-> !$past(DATA_VALID_STROBE_N_IN, 3)) else $error("rx no strobe");
  AST_DEF: assert property (##3 DEFERRED != $past(COMPLETION_POSTPONE_N, 3)) else $error("completion_postpone_n");
  AST_OWN: assert property (!DATA_BUS_IN_USE_N_IN && DATA_BUS_IN_USE_N_OUT |-> !DATA_N_OE) else $error("clash");
endmodule
bind sysbus_data_phase sysbus_data_phase_checker #(.WIDTH(WIDTH)) chk (.*);

// [verification/sysbus_data_phase_tb_top.sv]
// Self-checking bench for the data-phase block against a peer agent.
module sysbus_data_phase_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK, RST_B, ECC_STRAP_N, TX_VALID, TX_READY, TX_LAST, TX_PAUSE, RX_VALID, RX_CHECK_ERROR;
  logic DEFERRED, ECC_ON, BUS_OWNED, COMPLETION_POSTPONE_N, DATA_N_OE, DATA_CHECK_BITS_N_OE;
  logic DATA_VALID_STROBE_N_IN, DATA_VALID_STROBE_N_OUT, DATA_VALID_STROBE_N_OE, p_s, p_b, p_oe;
  logic DATA_BUS_IN_USE_N_IN, DATA_BUS_IN_USE_N_OUT, DATA_BUS_IN_USE_N_OE;
  logic [63:0] TX_DATA, DATA_N_IN, DATA_N_OUT, RX_DATA, p_d;
  logic [7:0] DATA_CHECK_BITS_N_IN, DATA_CHECK_BITS_N_OUT, p_c;
  int err_total, tests_run;
  sysbus_data_phase uut (.*);
  bus_peer_model peer (.clk(CLOCK), .busy_n(DATA_BUS_IN_USE_N_IN), .d(p_d), .c(p_c), .s(p_s), .b(p_b), .oe(p_oe));
  // Pulled-up shared lines: any driver can only pull them low.
  assign DATA_N_IN = (DATA_N_OE ? DATA_N_OUT : '1) & (p_oe ? p_d : '1);
  assign DATA_CHECK_BITS_N_IN = (DATA_CHECK_BITS_N_OE ? DATA_CHECK_BITS_N_OUT : '1) & (p_oe ? p_c : '1);
  assign DATA_VALID_STROBE_N_IN = (DATA_VALID_STROBE_N_OE ? DATA_VALID_STROBE_N_OUT : '1) & (p_oe ? p_s : '1);
  assign DATA_BUS_IN_USE_N_IN = (DATA_BUS_IN_USE_N_OE ? DATA_BUS_IN_USE_N_OUT : '1) & (p_oe ? p_b : '1);
  // Clock of 5 ns.
  initial begin
    CLOCK = 1'h0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  // Inputs move 1 ns after the edge, clear of the sampling instant.
  task automatic tick();
    @(posedge CLOCK);
    #1;
  endtask
  task automatic check(input string nm, input logic [63:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("%0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Follows n outbound words on the lines; check bits are inverted byte parity.
  task automatic watch(input logic [63:0] base, input int n);
    int k;
    logic [63:0] w;
    logic p;
    k = 0;
    p = 1'h0;
    for (int i = 0; i < 400 && k < n; i++) begin
      tick();
      w = base + k;
      if (p) check("pause", DATA_VALID_STROBE_N_OUT, 1'h1);
      check("overlap", DATA_N_OE & p_oe, 1'h0);
      if (DATA_VALID_STROBE_N_IN === 1'h0 && DATA_N_OE === 1'h1) begin
        check("data", DATA_N_IN, ~w);
        check("busy", DATA_BUS_IN_USE_N_IN, 1'h0);
        check("owned", BUS_OWNED, 1'h1);
        for (int j = 0; j < 8; j++) check("chk", DATA_CHECK_BITS_N_IN[j], ~^w[j*8 +: 8]);
        k++;
      end
      p = (i % 5 == 2);
      TX_PAUSE = p;
    end
    TX_PAUSE = 1'h0;
    check("tx_n", k, n);
    if (k < n) results();
    // Our own words must not come back as received ones.
    repeat (4) begin
      tick();
      check("rx_echo", RX_VALID, 1'h0);
    end
  endtask
  // Four peer words with an idle clock after the first; bad spoils the check lines.
  task automatic t_recv(input logic bad);
    int k;
    k = 0;
    fork
      peer.send(64'h1234_5678_9ABC_DEF0, 4, 1'h1, bad);
      for (int i = 0; i < 40 && k < 4; i++) begin
        tick();
        if (RX_VALID === 1'h1) begin
          check("rx", RX_DATA, 64'h1234_5678_9ABC_DEF0 + k);
          check("rx_err", RX_CHECK_ERROR, bad);
          k++;
        end
      end
    join
    check("rx_n", k, 4);
    if (k < 4) results();
  endtask
  // Peer holds the bus while the buffer fills until refused, then two-word phases drain.
  task automatic t_fill();
    int n;
    n = 0;
    fork
      peer.send(64'h0, 24, 1'h0, 1'h0);
      begin
        repeat (3) tick();
        TX_VALID = 1'h1;
        for (int i = 0; i < 20 && TX_READY === 1'h1; i++) begin
          TX_DATA = 64'hC0DE_0000_0000_0000 + n;
          TX_LAST = n % 2 == 1;
          tick();
          n++;
        end
        TX_VALID = 1'h0;
      end
    join
    check("depth", n >= 16 && n <= 17, 1'h1);
    watch(64'hC0DE_0000_0000_0000, n);
  endtask
  // Eight cycles of reset with the strap on, then each scenario in turn.
  initial begin
    {RST_B, TX_VALID, TX_LAST, TX_PAUSE, ECC_STRAP_N} = 5'h0;
    TX_DATA = 64'h0;
    COMPLETION_POSTPONE_N = 1'h1;
    repeat (8) tick();
    RST_B = 1'h1;
    repeat (4) tick();
    ECC_STRAP_N = 1'h1;
    check("ecc", ECC_ON, 1'h1);
    t_recv(1'h0);
    t_recv(1'h1);
    $display("receive done");
    COMPLETION_POSTPONE_N = 1'h0;
    repeat (4) tick();
    check("completion_postpone_n", DEFERRED, 1'h1);
    COMPLETION_POSTPONE_N = 1'h1;
    $display("completion_postpone_n done");
    t_fill();
    $display("fill done");
    results();
  end
endmodule
